// ===== shared/acd_pkg.sv
// constants and types of the accumulator add datapath
package acd_pkg;

    // ****************************************
    // register counts
    // ****************************************
    localparam int unsigned PTR_CNT = 6;
    localparam int unsigned ACC_CNT = 4;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_OPND   = 8'h04;
    localparam logic [7:0] ADDR_SHF    = 8'h08;
    localparam logic [7:0] ADDR_MOD    = 8'h0C;
    localparam logic [7:0] ADDR_CFG    = 8'h10;
    localparam logic [7:0] ADDR_PROD   = 8'h14;
    localparam logic [7:0] ADDR_FLAGS  = 8'h18;
    localparam logic [7:0] ADDR_STAT   = 8'h1C;
    localparam logic [7:0] ADDR_PTR0   = 8'h20;
    localparam logic [7:0] ADDR_PTR_END = 8'h38;
    localparam logic [7:0] ADDR_ACC0   = 8'h40;
    localparam logic [7:0] ADDR_ACC_END = 8'h60;

    // ****************************************
    // cfg word field positions
    // ****************************************
    localparam int unsigned CFG_STEP_LSB = 0;
    localparam int unsigned CFG_WRAP_LSB = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0]  RST_SHF    = 2'h0;
    localparam logic [5:0]  RST_MODEN  = 6'h00;
    localparam logic [6:0]  RST_STEP   = 7'h01;
    localparam logic [8:0]  RST_WRAP   = 9'h1FF;
    localparam logic [15:0] RST_PTR    = 16'h0000;
    localparam logic [35:0] RST_ACC    = 36'h0_0000_0000;
    localparam logic [31:0] RST_PROD   = 32'h0000_0000;
    localparam logic [31:0] RST_OPND   = 32'h0000_0000;

    // ****************************************
    // execution cycles
    // ****************************************
    localparam logic [1:0] CYC_ONE_WORD = 2'h1;
    localparam logic [1:0] CYC_TWO_WORD = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        OP_NOP   = 4'b0000,
        OP_ADD   = 4'b0001,
        OP_ADDH  = 4'b0010,
        OP_MOVA  = 4'b0011,
        OP_MOVL  = 4'b0100,
        OP_MOVH  = 4'b0101,
        OP_MOVHD = 4'b0110,
        OP_MAC   = 4'b0111,
        OP_MAA   = 4'b1000,
        OP_MUL   = 4'b1001,
        OP_MODR  = 4'b1010
    } acd_op_t;

    typedef enum logic [1:0] {
        PM_KEEP = 2'b00,
        PM_INC  = 2'b01,
        PM_DEC  = 2'b10,
        PM_STEP = 2'b11
    } acd_pm_t;

    typedef enum logic [2:0] {
        CC_TRUE = 3'b000,
        CC_EQ   = 3'b001,
        CC_NEQ  = 3'b010,
        CC_GT   = 3'b011,
        CC_GE   = 3'b100,
        CC_LT   = 3'b101,
        CC_LE   = 3'b110,
        CC_V    = 3'b111
    } acd_cc_t;

    // command word, op in the low bits
    typedef struct packed {
        logic    twoWord;
        acd_cc_t cond;
        logic    useProd;
        logic    indirect;
        logic    keepExt;
        acd_pm_t postMod;
        logic [2:0] ptrSel;
        logic [1:0] accSel;
        acd_op_t op;
    } acd_cmd_t;

    typedef struct packed {
        logic z;
        logic m;
        logic n;
        logic v;
        logic c;
        logic e;
        logic l;
        logic r;
    } acd_flags_t;

endpackage : acd_pkg

// ===== hw/acd_alu36.sv
// 36-bit two's complement adder with flag generation
`timescale 1ns/10ps
module acd_alu36 (
    input  wire logic [35:0]        opA,
    input  wire logic [35:0]        opB,
    input  wire acd_pkg::acd_flags_t flagsIn,
    output acd_pkg::acd_flags_t     flagsOut,
    output logic [35:0]             sum
);
    logic [36:0] wide;

    always_comb begin
        wide = {1'b0, opA} + {1'b0, opB};
        sum = wide[35:0];
        flagsOut.z = (wide[35:0] == 36'h0_0000_0000);
        flagsOut.m = wide[35];
        flagsOut.v = (opA[35] == opB[35]) && (wide[35] != opA[35]);
        flagsOut.c = wide[36];
        // extension in use: bits 35..31 not all sign copies
        flagsOut.e = (wide[35:31] != 5'h00) && (wide[35:31] != 5'h1F);
        flagsOut.n = flagsOut.z | (~flagsOut.e & (wide[31] ^ wide[30]));
        // sticky limit: only reset or a software write clears it
        flagsOut.l = flagsIn.l | flagsOut.v;
        flagsOut.r = flagsIn.r;
    end

endmodule : acd_alu36

// ===== hw/acd_datapath.sv
// accumulator add datapath: register port, pointer update, accumulator writes
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
//
// Function
// [RULE1] indirect pointer post-modify: keep, +1, -1, +step
// [RULE2] step is 7-bit signed, -64 to 63
// [RULE3] 9-bit wrap size, only when enabled
// [RULE4] product write-only, loaded by multiply
// [RULE5] product sign-extended to 36 bits into alu
// [RULE6] product shifted by shift field, stored unchanged
// [RULE7] aligned multiply-accumulate shifts product right 16
// [RULE8] whole-accumulator moves sign-extend
// [RULE9] low-word write clears high and extension
// [RULE10] high-word write clears low, sign-extends
// [RULE11] direct high move may keep extension
// [RULE12] 16-bit operand sign-extended to 36 bits
// [RULE13] software tests flags right after setting
// [RULE14] absent condition means always true
// [RULE15] no same accumulator source and destination
// [RULE16] no indexed access right after base change
// [RULE17] two idle slots after program counter write
// [RULE18] add updates seven flags, keeps R
// [RULE19] add takes one or two cycles
// [RULE20] add-to-high adds operand shifted 16
// [RULE21] add-to-high operand not accumulator or product
// [RULE22] accumulators 36 bits: low, high, extension
// [RULE23] access uses pointer before post-modify
module acd_datapath (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // ****************************************
    // state
    // ****************************************
    logic [15:0]         pointer_regs [acd_pkg::PTR_CNT];
    logic [15:0]         next_pointer_regs [acd_pkg::PTR_CNT];
    logic [35:0]         accum [acd_pkg::ACC_CNT];
    logic [35:0]         next_accum [acd_pkg::ACC_CNT];
    logic [31:0]         product;
    logic [31:0]         next_product;
    acd_pkg::acd_flags_t flags;
    acd_pkg::acd_flags_t next_flags;
    logic [1:0]          product_shift_field;
    logic [1:0]          next_product_shift_field;
    logic [5:0]          status_word_two;
    logic [5:0]          next_status_word_two;
    logic [6:0]          increment_amount_i;
    logic [6:0]          next_increment_amount_i;
    logic [8:0]          wrap_size_i;
    logic [8:0]          next_wrap_size_i;
    logic [31:0]         opnd;
    logic [31:0]         next_opnd;
    acd_pkg::acd_cmd_t   cmdReg;
    acd_pkg::acd_cmd_t   next_cmdReg;
    logic [1:0]          busyCnt;
    logic [1:0]          next_busyCnt;
    logic [15:0]         lastAddr;
    logic [15:0]         next_lastAddr;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;

    // ****************************************
    // operand shaping
    // ****************************************
    logic [35:0]         prodExt;
    logic [35:0]         prodShifted;
    logic [35:0]         prodAligned;
    logic [35:0]         opndExt;
    logic [35:0]         aluA;
    logic [35:0]         aluB;
    logic [35:0]         aluSum;
    acd_pkg::acd_flags_t aluFlags;
    logic [1:0]          firstBankIdx;
    logic [1:0]          accIdx;

    always_comb begin
        prodExt = {{4{product[31]}}, product}; // RULE5
        case (product_shift_field) // RULE6
            2'h1: prodShifted = {prodExt[35], prodExt[35:1]};
            2'h2: prodShifted = {prodExt[34:0], 1'b0};
            2'h3: prodShifted = {prodExt[33:0], 2'b00};
            default: prodShifted = prodExt;
        endcase
        prodAligned = {{16{prodShifted[35]}}, prodShifted[35:16]}; // RULE7
        opndExt = {{20{opnd[15]}}, opnd[15:0]}; // RULE12
        // add and add-to-high use the first bank only
        firstBankIdx = {1'b0, cmdReg.accSel[0]};
        accIdx = cmdReg.accSel;
        aluA = accum[firstBankIdx];
        aluB = opndExt;
        case (cmdReg.op)
            acd_pkg::OP_ADD: begin
                aluB = cmdReg.useProd ? prodShifted : opndExt;
            end
            acd_pkg::OP_ADDH: begin
                // zero low half keeps the low word
                aluB = {opndExt[19:0], 16'h0000}; // RULE20
            end
            acd_pkg::OP_MAC: begin
                aluA = accum[accIdx];
                aluB = prodShifted;
            end
            acd_pkg::OP_MAA: begin
                aluA = accum[accIdx];
                aluB = prodAligned; // RULE7
            end
            default: begin
                aluB = opndExt;
            end
        endcase
    end

    acd_alu36 u_alu (
        .opA      (aluA),
        .opB      (aluB),
        .flagsIn  (flags),
        .flagsOut (aluFlags),
        .sum      (aluSum)
    );

    // ****************************************
    // pointer post-modification
    // ****************************************
    function automatic logic [15:0] postModify(
        input logic [15:0]     cur,
        input acd_pkg::acd_pm_t mode,
        input logic [6:0]      stepv,
        input logic [8:0]      wrapv,
        input logic            modOn
    );
        logic [9:0]  delta;
        logic [10:0] off;
        logic [10:0] lim;
        begin
            case (mode) // RULE1
                acd_pkg::PM_INC:  delta = 10'h001;
                acd_pkg::PM_DEC:  delta = 10'h3FF;
                acd_pkg::PM_STEP: delta = {{3{stepv[6]}}, stepv}; // RULE2
                default:          delta = 10'h000;
            endcase
            lim = {2'b00, wrapv};
            off = {2'b00, cur[8:0]} + {delta[9], delta};
            if (modOn && (mode != acd_pkg::PM_KEEP)) begin // RULE3
                // wrap+1 word window in the aligned 512-word page
                if (off[10]) begin
                    off = off + lim + 11'h001;
                end else if ($signed(off) > $signed(lim)) begin
                    off = off - lim - 11'h001;
                end
                postModify = {cur[15:9], off[8:0]};
            end else begin
                postModify = cur + {{6{delta[9]}}, delta};
            end
        end
    endfunction : postModify

    // ****************************************
    // next-state logic
    // ****************************************
    logic        access;
    logic        commit;
    logic        hit;
    logic        isCmd;
    logic [31:0] rdata;
    logic        condTrue;
    logic [2:0]  pIdx;
    logic [1:0]  aIdx;

    always_comb begin
        for (int i = 0; i < acd_pkg::PTR_CNT; i++) begin
            next_pointer_regs[i] = pointer_regs[i];
        end
        for (int i = 0; i < acd_pkg::ACC_CNT; i++) begin
            next_accum[i] = accum[i];
        end
        next_product = product;
        next_flags = flags;
        next_product_shift_field = product_shift_field;
        next_status_word_two = status_word_two;
        next_increment_amount_i = increment_amount_i;
        next_wrap_size_i = wrap_size_i;
        next_opnd = opnd;
        next_cmdReg = cmdReg;
        next_busyCnt = busyCnt;
        next_lastAddr = lastAddr;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        pIdx = cmdReg.ptrSel;
        aIdx = cmdReg.accSel;

        // condition on the current flags
        case (cmdReg.cond) // RULE14
            acd_pkg::CC_EQ:  condTrue = flags.z;
            acd_pkg::CC_NEQ: condTrue = ~flags.z;
            acd_pkg::CC_GT:  condTrue = ~flags.m & ~flags.z;
            acd_pkg::CC_GE:  condTrue = ~flags.m;
            acd_pkg::CC_LT:  condTrue = flags.m;
            acd_pkg::CC_LE:  condTrue = flags.m | flags.z;
            acd_pkg::CC_V:   condTrue = flags.v;
            default:         condTrue = 1'b1;
        endcase

        // ---- execution: result lands at the last busy edge ----
        if (busyCnt != 2'h0) begin
            next_busyCnt = busyCnt - 2'h1; // RULE19
        end
        if ((busyCnt == acd_pkg::CYC_ONE_WORD) && condTrue) begin
            if (cmdReg.indirect && (pIdx < 3'(acd_pkg::PTR_CNT))) begin
                next_lastAddr = pointer_regs[pIdx]; // RULE23
                next_pointer_regs[pIdx] = postModify(pointer_regs[pIdx],
                    cmdReg.postMod, increment_amount_i, wrap_size_i,
                    status_word_two[pIdx]); // RULE1
            end
            case (cmdReg.op)
                acd_pkg::OP_ADD, acd_pkg::OP_ADDH: begin
                    next_accum[firstBankIdx] = aluSum; // RULE18
                    next_flags = aluFlags; // RULE18
                end
                acd_pkg::OP_MAC, acd_pkg::OP_MAA: begin
                    next_accum[aIdx] = aluSum;
                    next_flags = aluFlags;
                end
                acd_pkg::OP_MOVA: begin
                    // the only move that copies the product out
                    next_accum[aIdx] = cmdReg.useProd ? prodShifted
                                                      : opndExt; // RULE8
                end
                acd_pkg::OP_MOVL: begin
                    next_accum[aIdx] = {20'h0_0000, opnd[15:0]}; // RULE9
                end
                acd_pkg::OP_MOVH: begin
                    next_accum[aIdx] = {{4{opnd[15]}}, opnd[15:0],
                                        16'h0000}; // RULE10
                end
                acd_pkg::OP_MOVHD: begin
                    next_accum[aIdx] = {cmdReg.keepExt ? accum[aIdx][35:32]
                                                       : {4{opnd[15]}},
                                        opnd[15:0], 16'h0000}; // RULE11
                end
                acd_pkg::OP_MUL: begin
                    next_product = 32'($signed(opnd[15:0])
                                       * $signed(opnd[31:16])); // RULE4
                end
                default: begin
                    next_product = product;
                end
            endcase
        end

        // ---- bus decode ----
        access = psel & penable;
        commit = access & pready & ~pslverr;
        isCmd = (paddr == acd_pkg::ADDR_CMD);
        hit = 1'b1;
        rdata = 32'h0000_0000;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (isCmd) begin
            rdata = {14'h0000, cmdReg};
        end else if (paddr == acd_pkg::ADDR_OPND) begin
            rdata = opnd;
        end else if (paddr == acd_pkg::ADDR_SHF) begin
            rdata = {30'h0000_0000, product_shift_field};
        end else if (paddr == acd_pkg::ADDR_MOD) begin
            rdata = {26'h000_0000, status_word_two};
        end else if (paddr == acd_pkg::ADDR_CFG) begin
            rdata = {16'h0000, wrap_size_i, increment_amount_i};
        end else if (paddr == acd_pkg::ADDR_PROD) begin
            rdata = 32'h0000_0000; // RULE4
        end else if (paddr == acd_pkg::ADDR_FLAGS) begin
            rdata = {24'h00_0000, flags};
        end else if (paddr == acd_pkg::ADDR_STAT) begin
            rdata = {lastAddr, 14'h0000, busyCnt};
        end else if ((paddr >= acd_pkg::ADDR_PTR0)
                     && (paddr < acd_pkg::ADDR_PTR_END)) begin
            rdata = {16'h0000, pointer_regs[paddr[4:2]]};
        end else if ((paddr >= acd_pkg::ADDR_ACC0)
                     && (paddr < acd_pkg::ADDR_ACC_END)) begin
            rdata = paddr[2] ? {28'h000_0000, accum[paddr[4:3]][35:32]}
                             : accum[paddr[4:3]][31:0]; // RULE22
        end else begin
            hit = 1'b0;
        end

        // ---- bus answer: one wait state; a command waits while busy ----
        if (access && !pready) begin
            if (!hit) begin
                next_pready = 1'b1;
                next_pslverr = 1'b1;
            end else if (isCmd && pwrite && (busyCnt != 2'h0)) begin
                next_pready = 1'b0;
            end else begin
                next_pready = 1'b1;
                next_prdata = pwrite ? 32'h0000_0000 : rdata;
            end
        end

        // ---- writes land on the accepting edge ----
        if (commit && pwrite) begin
            if (isCmd) begin
                next_cmdReg = acd_pkg::acd_cmd_t'(pwdata[17:0]);
                next_busyCnt = pwdata[17] ? acd_pkg::CYC_TWO_WORD
                                          : acd_pkg::CYC_ONE_WORD; // RULE19
            end else if (paddr == acd_pkg::ADDR_OPND) begin
                next_opnd = pwdata;
            end else if (paddr == acd_pkg::ADDR_SHF) begin
                next_product_shift_field = pwdata[1:0];
            end else if (paddr == acd_pkg::ADDR_MOD) begin
                next_status_word_two = pwdata[5:0];
            end else if (paddr == acd_pkg::ADDR_CFG) begin
                next_increment_amount_i = pwdata[acd_pkg::CFG_STEP_LSB +: 7];
                next_wrap_size_i = pwdata[acd_pkg::CFG_WRAP_LSB +: 9];
            end else if (paddr == acd_pkg::ADDR_PROD) begin
                next_product = pwdata; // RULE4
            end else if (paddr == acd_pkg::ADDR_FLAGS) begin
                next_flags = acd_pkg::acd_flags_t'(pwdata[7:0]);
            end else if ((paddr >= acd_pkg::ADDR_PTR0)
                         && (paddr < acd_pkg::ADDR_PTR_END)) begin
                // a software write beats a same-edge post-modify
                next_pointer_regs[paddr[4:2]] = pwdata[15:0];
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < acd_pkg::PTR_CNT; i++) begin
                pointer_regs[i] <= acd_pkg::RST_PTR;
            end
            for (int i = 0; i < acd_pkg::ACC_CNT; i++) begin
                accum[i] <= acd_pkg::RST_ACC;
            end
            product <= acd_pkg::RST_PROD;
            flags <= '0;
            product_shift_field <= acd_pkg::RST_SHF;
            status_word_two <= acd_pkg::RST_MODEN;
            increment_amount_i <= acd_pkg::RST_STEP;
            wrap_size_i <= acd_pkg::RST_WRAP;
            opnd <= acd_pkg::RST_OPND;
            cmdReg <= '0;
            busyCnt <= 2'h0;
            lastAddr <= acd_pkg::RST_PTR;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            for (int i = 0; i < acd_pkg::PTR_CNT; i++) begin
                pointer_regs[i] <= next_pointer_regs[i];
            end
            for (int i = 0; i < acd_pkg::ACC_CNT; i++) begin
                accum[i] <= next_accum[i];
            end
            product <= next_product;
            flags <= next_flags;
            product_shift_field <= next_product_shift_field;
            status_word_two <= next_status_word_two;
            increment_amount_i <= next_increment_amount_i;
            wrap_size_i <= next_wrap_size_i;
            opnd <= next_opnd;
            cmdReg <= next_cmdReg;
            busyCnt <= next_busyCnt;
            lastAddr <= next_lastAddr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : acd_datapath

// ===== tb/acd_datapath_chk.sv
// port checker for the accumulator add datapath
`timescale 1ns/10ps
module acd_datapath_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // bus answer timing and read-back shape
    // ****************************************
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready over one cycle");
    property p_errrdy; pslverr |-> pready; endproperty
    a_errrdy: assert property (p_errrdy) else $error("error without ready");
    property p_cause; !(psel && penable) |=> !pready; endproperty
    a_cause: assert property (p_cause) else $error("ready without access");
    property p_wait; psel && penable && !$past(penable) |-> !pready; endproperty
    a_wait: assert property (p_wait) else $error("no wait state");
    property p_ans;
        psel && penable && !pready && !(pwrite && paddr == acd_pkg::ADDR_CMD) |=> pready;
    endproperty
    a_ans: assert property (p_ans) else $error("late answer");
    property p_cmd; psel && penable && pwrite && paddr == acd_pkg::ADDR_CMD |-> ##[0:4] pready;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command stall too long");
    property p_prod; pready && !pwrite && paddr == acd_pkg::ADDR_PROD |-> prdata == '0;
    endproperty
    a_prod: assert property (p_prod) else $error("product readable");
    property p_ext;
        pready && !pwrite && paddr >= acd_pkg::ADDR_ACC0 && paddr < acd_pkg::ADDR_ACC_END
        && paddr[2] |-> prdata[31:4] == '0;
    endproperty
    a_ext: assert property (p_ext) else $error("ext word too wide");
endmodule : acd_datapath_chk

bind acd_datapath acd_datapath_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// ===== tb/tb_acd_datapath.sv
// testbench for the accumulator add datapath
`timescale 1ns/10ps
module tb_acd_datapath;
    logic        clk         = 1'b0;
    logic        rst_n       = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] lastData;
    logic        lastErr;
    int          n_fail      = 0;
    int          comparisons = 0;
    logic [35:0] prodTab [4] = '{36'hF_FFFF_FFFA, 36'hF_FFFF_FFFD, 36'hF_FFFF_FFF4,
                                 36'hF_FFFF_FFE8};
    logic [15:0] ptrTab [4]  = '{16'h0010, 16'h0011, 16'h0010, 16'hFFD0};

    always #50 clk = ~clk;

    acd_datapath i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic final_report;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // idle edge after each transfer: no signal driven twice in a step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        lastData = prdata;
        lastErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [35:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk({4'h0, lastData}, exp);
    endtask : rd

    task automatic rdacc(input logic [1:0] i, input logic [35:0] exp);
        rd(acd_pkg::ADDR_ACC0 + {3'h0, i, 3'h0}, {4'h0, exp[31:0]});
        rd(acd_pkg::ADDR_ACC0 + {3'h0, i, 3'h4}, {32'h0000_0000, exp[35:32]});
    endtask : rdacc

    task automatic run(input logic [31:0] opnd, input logic [31:0] cmd);
        xfer(1'b1, acd_pkg::ADDR_OPND, opnd);
        xfer(1'b1, acd_pkg::ADDR_CMD, cmd);
        do xfer(1'b0, acd_pkg::ADDR_STAT, 32'h0000_0000);
        while (lastData[1:0] !== 2'h0);
    endtask : run

    function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] acc,
                                       input logic [2:0] ptr, input logic [1:0] pm,
                                       input logic [2:0] xf, input logic [2:0] cond);
        return {14'h0000, 1'b0, cond, xf, pm, ptr, acc, op};
    endfunction : mk

    initial begin : main
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(acd_pkg::ADDR_CFG, 36'hFF81);
        rd(acd_pkg::ADDR_PROD, 36'h0);
        xfer(1'b0, 8'h80, 32'h0000_0000);
        chk({35'h0, lastErr}, 36'h1);
        xfer(1'b0, 8'h22, 32'h0000_0000);
        chk({35'h0, lastErr}, 36'h1);
        xfer(1'b1, acd_pkg::ADDR_FLAGS, 32'h0000_0001);
        run(32'h0000_8000, mk(4'h1, 2'h0, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h0, 36'hF_FFFF_8000);
        rd(acd_pkg::ADDR_FLAGS, 36'h41);
        run(32'h0000_8001, mk(4'h5, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h1, 36'hF_8001_0000);
        run(32'h0000_9234, mk(4'h4, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h1, 36'h0_0000_9234);
        run(32'h0000_FFFF, mk(4'h2, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h1, 36'hF_FFFF_9234);
        run(32'h0000_1234, mk(4'h6, 2'h0, 3'h0, 2'h0, 3'h1, 3'h0));
        rdacc(2'h0, 36'hF_1234_0000);
        run(32'h0000_1234, mk(4'h6, 2'h0, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h0, 36'h0_1234_0000);
        run(32'h0000_8000, mk(4'h3, 2'h0, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h0, 36'hF_FFFF_8000);
        run(32'h0003_FFFE, mk(4'h9, 2'h0, 3'h0, 2'h0, 3'h0, 3'h0));
        rd(acd_pkg::ADDR_PROD, 36'h0);
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, acd_pkg::ADDR_SHF, 32'(s));
            run(32'h0000_0000, mk(4'h3, 2'h0, 3'h0, 2'h0, 3'h4, 3'h0));
            rdacc(2'h0, prodTab[s]);
        end
        xfer(1'b1, acd_pkg::ADDR_SHF, 32'h0000_0000);
        run(32'h0004_4000, mk(4'h9, 2'h0, 3'h0, 2'h0, 3'h0, 3'h0));
        run(32'h0000_0000, mk(4'h4, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        run(32'h0000_0000, mk(4'h8, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h1, 36'h1);
        run(32'h0000_0000, mk(4'h7, 2'h1, 3'h0, 2'h0, 3'h0, 3'h0));
        rdacc(2'h1, 36'h0_0001_0001);
        // ****************************************
        // pointer post-modify and wrap
        // ****************************************
        xfer(1'b1, acd_pkg::ADDR_PTR0, 32'h0000_0010);
        xfer(1'b1, acd_pkg::ADDR_CFG, 32'h0000_FFC0);
        for (int m = 0; m < 4; m++) begin
            run(32'h0000_0000, mk(4'hA, 2'h0, 3'h0, 2'(m), 3'h2, 3'h0));
            rd(acd_pkg::ADDR_PTR0, {20'h0_0000, ptrTab[m]});
        end
        run(32'h0000_0000, mk(4'h1, 2'h0, 3'h0, 2'h1, 3'h2, 3'h0));
        rd(acd_pkg::ADDR_STAT, 36'h0_FFD0_0000);
        xfer(1'b1, acd_pkg::ADDR_STAT, 32'h0000_0003);
        rd(acd_pkg::ADDR_STAT, 36'h0_FFD0_0000);
        rd(acd_pkg::ADDR_PTR0, 36'hFFD1);
        xfer(1'b1, acd_pkg::ADDR_MOD, 32'h0000_0001);
        xfer(1'b1, acd_pkg::ADDR_CFG, 32'h0000_0781);
        xfer(1'b1, acd_pkg::ADDR_PTR0, 32'h0000_000F);
        xfer(1'b1, acd_pkg::ADDR_PTR0 + 8'h04, 32'h0000_000F);
        run(32'h0000_0000, mk(4'hA, 2'h0, 3'h0, 2'h1, 3'h2, 3'h0));
        run(32'h0000_0000, mk(4'hA, 2'h0, 3'h1, 2'h1, 3'h2, 3'h0));
        rd(acd_pkg::ADDR_PTR0, 36'h0);
        rd(acd_pkg::ADDR_PTR0 + 8'h04, 36'h10);
        xfer(1'b1, acd_pkg::ADDR_FLAGS, 32'h0000_0000);
        run(32'h0000_0001, mk(4'h1, 2'h1, 3'h0, 2'h0, 3'h0, 3'h1));
        rdacc(2'h1, 36'h0_0001_0001);
        run(32'h0000_0001, mk(4'h1, 2'h1, 3'h0, 2'h0, 3'h0, 3'h2) | 32'h0002_0000);
        rdacc(2'h1, 36'h0_0001_0002);
        final_report();
    end

    initial begin : watchdog
        repeat (5000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : tb_acd_datapath
